// [rtl/pdb_data_block.sv]
// Summary of operation
// R1 - Converter offset of two to the power of setup bits 14:11 is removed.
// R2 - Software keeps the offset exponent matched to the calibration DAC.
// R3 - Checksum seed is all zeros when setup bit 15 is 0, else all ones.
// R4 - Control bit 0 enables automatic black calibration; 0 bypasses it.
// R5 - Without auto calibration the nine-bit manual value in bits 9:1 applies.
// R6 - Manual value is added when bit 10 is 0, subtracted when 1.
// R7 - Eleven-bit samples compress to ten bits unless bit 11 is set.
// R8 - Bit 12 passes raw sample bits 9:0 past correction and compression, for test only; narrow mode still applies.
// R9 - Bit 13 selects eight-bit output and delays sync codes four cycles.
// R10 - Idle data lanes carry the programmable training word, default 0x3A6.
// R11 - Receiver aligns words on the repeating training word first.
// R12 - Frame/line code: seven low bits, plus frame, start, end flags.
// R13 - Dark pixel words carry the dark marker code on the sync lane.
// R14 - Valid pixel words carry the valid marker code on the sync lane.
// R15 - Checksum words carry the checksum marker code on the sync lane.
// R16 - Idle periods carry the alignment marker code on the sync lane.
// R17 - Fault flag sets when too few dark samples were seen.
// R18 - Checksum reloads with the seed at the start of each line.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Dual-clock word FIFO, gray-coded pointers
// ------------------------------------------------------------------
module pdb_fifo
   import pdb_pkg::*;
#(
   parameter int W     = 20,
   parameter int DEPTH = 16
) (
   input  wire logic         wr_clk,
   input  wire logic         rd_clk,
   input  wire logic         nrst,
   input  wire logic         wr_valid,
   output logic              wr_ready,
   input  wire logic [W-1:0] wr_data,
   output logic              rd_valid,
   input  wire logic         rd_ready,
   output logic [W-1:0]      rd_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wbin;
      logic [AW:0]             wgray;
      logic [AW:0]             rg1;
      logic [AW:0]             rg2;
   } pdb_fw_t;

   typedef struct packed {
      logic [AW:0]  rbin;
      logic [AW:0]  rgray;
      logic [AW:0]  wg1;
      logic [AW:0]  wg2;
      logic         v;
      logic [W-1:0] d;
   } pdb_fr_t;

   pdb_fw_t ws;
   pdb_fw_t next_ws;
   pdb_fr_t rs;
   pdb_fr_t next_rs;
   logic    empty;
   logic    pop;

   // Full compares against the read pointer seen two stages late,
   // so full may linger a little; it never lies about free room
   assign wr_ready = ws.wgray != {~ws.rg2[AW:AW-1], ws.rg2[AW-2:0]};
   assign empty    = rs.rgray == rs.wg2;
   assign pop      = !empty && (!rs.v || rd_ready);
   assign rd_valid = rs.v;
   assign rd_data  = rs.d;

   // Write side
   always_comb begin
      next_ws     = ws;
      next_ws.rg1 = rs.rgray;
      next_ws.rg2 = ws.rg1;
      if (wr_valid && wr_ready) begin
         next_ws.mem[ws.wbin[AW-1:0]] = wr_data;
         next_ws.wbin  = ws.wbin + 1'b1;
         next_ws.wgray = next_ws.wbin ^ (next_ws.wbin >> 1);
      end
   end

   always_ff @(posedge wr_clk or negedge nrst) begin
      if (!nrst) begin
         ws <= '0;
      end else begin
         ws <= next_ws;
      end
   end

   // Read side, output word held in a register
   always_comb begin
      next_rs     = rs;
      next_rs.wg1 = ws.wgray;
      next_rs.wg2 = rs.wg1;
      if (pop) begin
         next_rs.d     = ws.mem[rs.rbin[AW-1:0]];
         next_rs.v     = 1'b1;
         next_rs.rbin  = rs.rbin + 1'b1;
         next_rs.rgray = next_rs.rbin ^ (next_rs.rbin >> 1);
      end else if (rd_ready) begin
         next_rs.v = 1'b0;
      end
   end

   always_ff @(posedge rd_clk or negedge nrst) begin
      if (!nrst) begin
         rs <= '0;
      end else begin
         rs <= next_rs;
      end
   end
endmodule

// ------------------------------------------------------------------
// Output data block: correction, compression, framing, lanes
// ------------------------------------------------------------------
module pdb_data_block
   import pdb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        link_clk,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   input  wire logic        pix_valid,
   output logic             pix_ready,
   input  wire logic [10:0] pix_data,
   input  wire logic        pix_dark,
   input  wire logic        pix_first,
   input  wire logic        pix_last,
   input  wire logic        pix_frame,
   output logic [9:0]       lane_data,
   output logic [9:0]       lane_sync
);
   typedef struct packed {
      logic [15:0] setup;
      logic [15:0] ctrl;
      logic [15:0] idle;
      logic [15:0] frm;
      logic [15:0] dark;
      logic [15:0] vld;
      logic [15:0] csum;
      logic [15:0] align;
      logic [15:0] err;
      logic [15:0] rdata;
      logic [17:0] acc;
      logic [7:0]  cnt;
      logic [10:0] blk;
      logic [9:0]  crc;
      logic        crc_pend;
      logic        wv;
      logic [19:0] w;
   } pdb_core_t;

   typedef struct packed {
      logic [9:0]                idle1;
      logic [9:0]                idle2;
      logic [9:0]                mark1;
      logic [9:0]                mark2;
      logic                      nar1;
      logic                      nar2;
      logic                      ce1;
      logic                      ce2;
      logic [SYNC_DLY-1:0][9:0]  dly;
      logic [9:0]                d;
      logic [9:0]                s;
   } pdb_link_t;

   pdb_core_t          st;
   pdb_core_t          next_st;
   pdb_link_t          ls;
   pdb_link_t          next_ls;
   logic               f_wready;
   logic               f_rvalid;
   logic [WORD_W-1:0]  f_rdata;
   logic               fire;
   logic signed [19:0] base;
   logic signed [19:0] corr;
   logic [17:0]        adc_ofs;
   logic [10:0]        v11;
   logic [9:0]         d10;
   logic [9:0]         sync_w;
   logic [8:0]         need;
   logic [7:0]         cnt_nx;
   logic [17:0]        acc_nx;
   logic [9:0]         cand_d;
   logic [9:0]         cand_s;

   function automatic logic [9:0] crc_step(input logic [9:0] c,
                                           input logic [9:0] d);
      logic [9:0] r;
      logic       fb;
      r = c;
      for (int i = 9; i >= 0; i--) begin
         fb = r[9] ^ d[i];
         r  = {r[8:0], 1'b0};
         if (fb) begin
            r = r ^ CRC_POLY;
         end
      end
      return r;
   endfunction

   // No new pixel while a word waits or a checksum is owed
   assign pix_ready = ce && (!st.wv || f_wready) && !st.crc_pend;
   assign fire      = pix_valid && pix_ready;
   assign reg_rdata = st.rdata;
   assign lane_data = ls.d;
   assign lane_sync = ls.s;
   assign need      = 9'(1) << st.setup[SU_SMP_MSB:SU_SMP_LSB];

   // ----------------------------------------------------------------
   // Pixel arithmetic
   // ----------------------------------------------------------------
   always_comb begin
      // R1 converter offset removal
      adc_ofs = 18'(1) << st.setup[SU_OFS_MSB:SU_OFS_LSB];
      base    = signed'(20'(pix_data)) - signed'(20'(adc_ofs));
      if (base < 0) begin
         base = '0;
      end
      // R4 auto or manual black
      if (st.ctrl[DP_AUTO]) begin
         corr = base + signed'(20'(st.setup[SU_BLK_MSB:SU_BLK_LSB]))
              - signed'(20'(st.blk));
      // R6 manual direction
      end else if (st.ctrl[DP_DEC]) begin
         corr = base - signed'(20'(st.ctrl[DP_MAN_MSB:DP_MAN_LSB]));
      // R5 manual value added
      end else begin
         corr = base + signed'(20'(st.ctrl[DP_MAN_MSB:DP_MAN_LSB]));
      end
      if (corr < 0) begin
         v11 = '0;
      end else if (corr > signed'(20'(PIX_MAX))) begin
         v11 = PIX_MAX;
      end else begin
         v11 = corr[10:0];
      end
      // R7 knee compression, or clipping when bypassed
      if (st.ctrl[DP_CMPB]) begin
         d10 = (v11 > WORD_MAX) ? WORD_MAX[9:0] : v11[9:0];
      end else if (v11 < CMP_KNEE) begin
         d10 = v11[9:0];
      end else begin
         d10 = 10'(CMP_KNEE + ((v11 - CMP_KNEE) >> CMP_SHIFT));
      end
      // R8 raw samples straight through
      if (st.ctrl[DP_BYP]) begin
         d10 = pix_data[9:0];
      end
      // R9 narrow words keep the top eight bits
      if (st.ctrl[DP_NARROW]) begin
         d10 = d10 >> NARROW_SH;
      end
      // R12 frame/line codes on line edges
      if (pix_first) begin
         sync_w           = {3'b000, st.frm[6:0]};
         sync_w[FS_TYPE]  = pix_frame;
         sync_w[FS_START] = 1'b1;
      end else if (pix_last) begin
         sync_w           = {3'b000, st.frm[6:0]};
         sync_w[FS_TYPE]  = pix_frame;
         sync_w[FS_END]   = 1'b1;
      // R13 dark marker
      end else if (pix_dark) begin
         sync_w = st.dark[9:0];
      // R14 valid marker
      end else begin
         sync_w = st.vld[9:0];
      end
   end

   // ----------------------------------------------------------------
   // Registers, calibration, checksum and word framing
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      acc_nx  = pix_first ? '0 : st.acc;
      cnt_nx  = pix_first ? '0 : st.cnt;
      // Reads see the state of the previous edge
      case (reg_addr)
         ADDR_SETUP: next_st.rdata = st.setup;
         ADDR_CTRL:  next_st.rdata = st.ctrl;
         ADDR_IDLE:  next_st.rdata = st.idle;
         ADDR_FRM:   next_st.rdata = st.frm;
         ADDR_DARK:  next_st.rdata = st.dark;
         ADDR_VALID: next_st.rdata = st.vld;
         ADDR_CSUM:  next_st.rdata = st.csum;
         ADDR_ALIGN: next_st.rdata = st.align;
         ADDR_ERR:   next_st.rdata = st.err;
         default:    next_st.rdata = RST_ZERO;
      endcase
      if (reg_wr) begin
         case (reg_addr)
            ADDR_SETUP: next_st.setup = reg_wdata;
            ADDR_CTRL:  next_st.ctrl  = reg_wdata;
            ADDR_IDLE:  next_st.idle  = reg_wdata & MSK_CODE;
            ADDR_FRM:   next_st.frm   = reg_wdata & MSK_FRM;
            ADDR_DARK:  next_st.dark  = reg_wdata & MSK_CODE;
            ADDR_VALID: next_st.vld   = reg_wdata & MSK_CODE;
            ADDR_CSUM:  next_st.csum  = reg_wdata & MSK_CODE;
            ADDR_ALIGN: next_st.align = reg_wdata & MSK_CODE;
            default:    next_st.rdata = next_st.rdata;
         endcase
      end
      if (st.wv && f_wready) begin
         next_st.wv = 1'b0;
      end
      // R15 checksum word follows the last pixel of a line
      if (st.crc_pend && !next_st.wv) begin
         next_st.w        = {st.csum[9:0], st.crc};
         next_st.wv       = 1'b1;
         next_st.crc_pend = 1'b0;
      end else if (fire) begin
         next_st.w  = {sync_w, d10};
         next_st.wv = 1'b1;
         // R18 seed reload on line start
         if (pix_first) begin
            // R3 seed selection
            next_st.crc = crc_step({10{st.setup[SU_SEED]}}, d10);
         end else begin
            next_st.crc = crc_step(st.crc, d10);
         end
         // Only the first 2**n dark samples of a line are averaged
         if (pix_dark && (9'(cnt_nx) < need)) begin
            acc_nx = acc_nx + base[17:0];
            cnt_nx = cnt_nx + 1'b1;
         end
         next_st.acc = acc_nx;
         next_st.cnt = cnt_nx;
         if (pix_last) begin
            next_st.crc_pend = 1'b1;
            // R17 dark fault flag, level kept when short
            if (9'(cnt_nx) < need) begin
               next_st.err[0] = 1'b1;
            end else begin
               next_st.err[0] = 1'b0;
               next_st.blk = 11'(acc_nx >> st.setup[SU_SMP_MSB:SU_SMP_LSB]);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st       <= '0;
         st.setup <= RST_SETUP;
         st.ctrl  <= RST_CTRL;
         st.idle  <= RST_IDLE;
         st.frm   <= RST_FRM;
         st.dark  <= RST_DARK;
         st.vld   <= RST_VALID;
         st.csum  <= RST_CSUM;
         st.align <= RST_ALIGN;
      end else if (ce) begin
         st <= next_st;
      end
   end

   pdb_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .wr_clk   (clk),
      .rd_clk   (link_clk),
      .nrst     (nrst),
      .wr_valid (st.wv && ce),
      .wr_ready (f_wready),
      .wr_data  (st.w),
      .rd_valid (f_rvalid),
      .rd_ready (ls.ce2),
      .rd_data  (f_rdata)
   );

   // ----------------------------------------------------------------
   // Link side lanes
   // ----------------------------------------------------------------
   // Config words are quasi-static; a two-stage catch suffices as long
   // as software does not rewrite them in mid-frame
   always_comb begin
      next_ls       = ls;
      next_ls.idle1 = st.idle[9:0];
      next_ls.idle2 = ls.idle1;
      next_ls.mark1 = st.align[9:0];
      next_ls.mark2 = ls.mark1;
      next_ls.nar1  = st.ctrl[DP_NARROW];
      next_ls.nar2  = ls.nar1;
      next_ls.ce1   = ce;
      next_ls.ce2   = ls.ce1;
      if (f_rvalid) begin
         cand_d = f_rdata[9:0];
         cand_s = f_rdata[19:10];
      // R10 training word when idle
      end else begin
         cand_d = ls.idle2;
         // R16 alignment marker when idle
         cand_s = ls.mark2;
      end
      if (ls.ce2) begin
         next_ls.d   = cand_d;
         next_ls.dly = {ls.dly[SYNC_DLY-2:0], cand_s};
         // R9 sync lane delayed in narrow mode
         next_ls.s   = ls.nar2 ? ls.dly[SYNC_DLY-1] : cand_s;
      end
   end

   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         ls <= '0;
      end else begin
         ls <= next_ls;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_bypass;
      @(posedge clk) disable iff (!nrst)
      (ce && fire && st.ctrl[DP_BYP] && !st.ctrl[DP_NARROW])
      |=> (st.w[9:0] == $past(pix_data[9:0])) && st.wv;
   endproperty
   a_bypass: assert property (p_bypass) // R8
      else $error("bypass word differs from raw sample");

   property p_cmp_max;
      @(posedge clk) disable iff (!nrst)
      (ce && fire && !st.ctrl[DP_BYP] && !st.ctrl[DP_CMPB])
      |=> st.w[9:0] <= CMP_MAX;
   endproperty
   a_cmp_max: assert property (p_cmp_max) // R7
      else $error("compressed word above knee range");

   property p_narrow;
      @(posedge clk) disable iff (!nrst)
      (ce && fire && st.ctrl[DP_NARROW]) |=> st.w[9:8] == 2'b00;
   endproperty
   a_narrow: assert property (p_narrow) // R9
      else $error("narrow word uses top two bits");

   property p_line_start;
      @(posedge clk) disable iff (!nrst)
      (ce && fire && pix_first)
      |=> st.w[10+FS_START] && (st.w[10+FS_TYPE] == $past(pix_frame));
   endproperty
   a_line_start: assert property (p_line_start) // R12
      else $error("line start code malformed");

   property p_dark_code;
      @(posedge clk) disable iff (!nrst)
      (ce && fire && pix_dark && !pix_first && !pix_last)
      |=> st.w[19:10] == $past(st.dark[9:0]);
   endproperty
   a_dark_code: assert property (p_dark_code) // R13
      else $error("dark pixel word lacks dark marker");

   property p_valid_code;
      @(posedge clk) disable iff (!nrst)
      (ce && fire && !pix_dark && !pix_first && !pix_last)
      |=> st.w[19:10] == $past(st.vld[9:0]);
   endproperty
   a_valid_code: assert property (p_valid_code) // R14
      else $error("valid pixel word lacks valid marker");

   property p_csum_word;
      @(posedge clk) disable iff (!nrst)
      (ce && fire && pix_last)
      |-> ##[1:200] (st.wv && st.w[19:10] == st.csum[9:0]);
   endproperty
   a_csum_word: assert property (p_csum_word) // R15
      else $error("no checksum word after line end");

   property p_fault;
      @(posedge clk) disable iff (!nrst)
      (ce && fire && pix_last)
      |=> st.err[0] == ($past(9'(cnt_nx)) < $past(need));
   endproperty
   a_fault: assert property (p_fault) // R17
      else $error("dark fault flag wrong after line");

   property p_idle;
      @(posedge link_clk) disable iff (!nrst)
      (ls.ce2 && !f_rvalid && !ls.nar2)
      |=> (lane_data == $past(ls.idle2)) && (lane_sync == $past(ls.mark2));
   endproperty
   a_idle: assert property (p_idle) // R10
      else $error("idle lanes not carrying training and marker");
endmodule

// [rtl/pdb_pkg.sv]
package pdb_pkg;

   // ----------------------------------------------------------------
   // Register addresses on the serial control port
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_SETUP = 8'h80;
   localparam logic [7:0]  ADDR_CTRL  = 8'h81;
   localparam logic [7:0]  ADDR_IDLE  = 8'h82;
   localparam logic [7:0]  ADDR_FRM   = 8'h83;
   localparam logic [7:0]  ADDR_DARK  = 8'h84;
   localparam logic [7:0]  ADDR_VALID = 8'h85;
   localparam logic [7:0]  ADDR_CSUM  = 8'h86;
   localparam logic [7:0]  ADDR_ALIGN = 8'h87;
   localparam logic [7:0]  ADDR_ERR   = 8'h88;

   // ----------------------------------------------------------------
   // Reset values and write masks
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_SETUP  = 16'h4008;
   localparam logic [15:0] RST_CTRL   = 16'hC001;
   localparam logic [15:0] RST_IDLE   = 16'h03A6;
   localparam logic [15:0] RST_FRM    = 16'h002A;
   localparam logic [15:0] RST_DARK   = 16'h0015;
   localparam logic [15:0] RST_VALID  = 16'h0035;
   localparam logic [15:0] RST_CSUM   = 16'h0059;
   localparam logic [15:0] RST_ALIGN  = 16'h03A6;
   localparam logic [15:0] RST_ZERO   = 16'h0000;
   localparam logic [15:0] MSK_CODE   = 16'h03FF;
   localparam logic [15:0] MSK_FRM    = 16'h007F;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SU_BLK_LSB  = 0;
   localparam int SU_BLK_MSB  = 7;
   localparam int SU_SMP_LSB  = 8;
   localparam int SU_SMP_MSB  = 10;
   localparam int SU_OFS_LSB  = 11;
   localparam int SU_OFS_MSB  = 14;
   localparam int SU_SEED     = 15;
   localparam int DP_AUTO     = 0;
   localparam int DP_MAN_LSB  = 1;
   localparam int DP_MAN_MSB  = 9;
   localparam int DP_DEC      = 10;
   localparam int DP_CMPB     = 11;
   localparam int DP_BYP      = 12;
   localparam int DP_NARROW   = 13;
   localparam int FS_TYPE     = 9;
   localparam int FS_START    = 8;
   localparam int FS_END      = 7;

   // ----------------------------------------------------------------
   // Datapath constants
   // ----------------------------------------------------------------
   localparam logic [9:0]  CRC_POLY   = 10'h233;
   localparam logic [10:0] CMP_KNEE   = 11'h200;
   localparam int          CMP_SHIFT  = 2;
   localparam logic [9:0]  CMP_MAX    = 10'h37F;
   localparam logic [10:0] PIX_MAX    = 11'h7FF;
   localparam logic [10:0] WORD_MAX   = 11'h3FF;
   localparam int          NARROW_SH  = 2;
   localparam int          SYNC_DLY   = 4;
   localparam int          FIFO_DEPTH = 16;
   localparam int          WORD_W     = 20;

endpackage

// [verification/pdb_data_block_bench.sv]
`timescale 1ns/1ps
module pdb_data_block_bench
   import pdb_pkg::*;
;
   logic        clk, link_clk, nrst, ce, reg_wr, locked;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic        pix_valid, pix_ready, pix_dark, pix_first, pix_last;
   logic        pix_frame;
   logic [10:0] pix_data;
   logic [9:0]  lane_data, lane_sync, idle_w, align_w, c;
   logic [9:0]  es [5];
   int          error_cnt, compares, n0d, n0s;
   // Mode table: setup, control, sample, expected output word
   logic [15:0] t_su [8] = '{16'h4008, 16'h4008, 16'h4008, 16'h4008,
                             16'h4008, 16'h4008, 16'hC008, 16'hC108};
   logic [15:0] t_ct [8] = '{16'h1000, 16'h0014, 16'h0414, 16'h0000,
                             16'h0800, 16'h2000, 16'h1000, 16'h0001};
   logic [10:0] t_px [8] = '{11'h123, 11'h150, 11'h150, 11'h500,
                             11'h500, 11'h150, 11'h150, 11'h150};
   logic [9:0]  t_ex [8] = '{10'h123, 10'h05A, 10'h046, 10'h280,
                             10'h3FF, 10'h014, 10'h150, 10'h008};
   logic [15:0] t_rs [9] = '{16'h4008, 16'hC001, 16'h03A6, 16'h002A,
                   16'h0015, 16'h0035, 16'h0059, 16'h03A6, 16'h0000};

   pdb_data_block u_dut (.clk(clk), .nrst(nrst), .ce(ce),
      .link_clk(link_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .pix_valid(pix_valid), .pix_ready(pix_ready),
      .pix_data(pix_data), .pix_dark(pix_dark), .pix_first(pix_first),
      .pix_last(pix_last), .pix_frame(pix_frame),
      .lane_data(lane_data), .lane_sync(lane_sync));
   pdb_rx_model u_rx (.link_clk(link_clk), .nrst(nrst),
      .lane_data(lane_data), .lane_sync(lane_sync), .idle_word(idle_w),
      .align_code(align_w), .locked(locked));

   // ----------------------------------------------------------------
   // Clocks: lane clock offset so the two never share an edge
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #1.3;
      forever #6 link_clk = ~link_clk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      #1;
      chk(reg_rdata, e);
   endtask
   // Ten-bit checksum, high bit first
   function automatic logic [9:0] crc_f(logic [9:0] s, logic [9:0] d);
      for (int i = 9; i >= 0; i--) begin
         s = (s << 1) ^ ((s[9] ^ d[i]) ? CRC_POLY : 10'h000);
      end
      return s;
   endfunction
   task automatic close_out;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {nrst, reg_wr, pix_valid, pix_dark, pix_first, pix_last} = '0;
      {pix_frame, reg_addr, reg_wdata, pix_data} = '0;
      {error_cnt, compares} = '0;
      ce = 1'b1;
      idle_w = 10'h3A6;
      align_w = 10'h3A6;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 9; k++) begin
         rd(8'h80 + 8'(k), t_rs[k]);
      end
      for (int k = 0; k < 100 && locked !== 1'b1; k++) @(posedge clk);
      chk(16'(locked), 16'h0001);
      chk(16'(lane_data), 16'h03A6);
      chk(16'(lane_sync), 16'h03A6);
      // A write offered while ce is low must not land
      ce <= 1'b0;
      wr(ADDR_DARK, 16'h0111);
      ce <= 1'b1;
      rd(ADDR_DARK, 16'h0015);
      for (int m = 0; m < 8; m++) begin
         wr(ADDR_SETUP, t_su[m]);
         wr(ADDR_CTRL, t_ct[m]);
         repeat (4) @(posedge clk);
         n0d = u_rx.nd;
         n0s = u_rx.ns;
         c = t_su[m][SU_SEED] ? 10'h3FF : 10'h000;
         es = '{{m[0], 2'b10, 7'h2A}, 10'h015, 10'h035,
                {m[0], 2'b01, 7'h2A}, 10'h059};
         for (int i = 0; i < 4; i++) begin
            pix_valid <= 1'b1;
            pix_data <= t_px[m];
            pix_dark <= (i == 1);
            pix_first <= (i == 0);
            pix_last <= (i == 3);
            pix_frame <= m[0];
            // Ready is judged before the edge that takes the sample
            @(negedge clk);
            while (pix_ready !== 1'b1) @(negedge clk);
            @(posedge clk);
            c = crc_f(c, t_ex[m]);
         end
         pix_valid <= 1'b0;
         for (int k = 0; k < 300 && (u_rx.ns < n0s + 5
              || u_rx.nd < n0d + 5); k++) @(posedge clk);
         for (int j = 0; j < 4; j++) begin
            chk(16'(u_rx.dq[n0d+j]), 16'(t_ex[m]));
         end
         chk(16'(u_rx.dq[n0d+4]), 16'(c));
         for (int j = 0; j < 5; j++) begin
            chk(16'(u_rx.sq[n0s+j]), 16'(es[j]));
         end
         chk(16'(u_rx.ts[n0s] - u_rx.td[n0d]),
             t_ct[m][DP_NARROW] ? 16'h0004 : 16'h0000);
      end
      wr(ADDR_IDLE, 16'hFD55);
      wr(ADDR_ALIGN, 16'h02AA);
      wr(ADDR_FRM, 16'hFFFF);
      wr(ADDR_ERR, 16'h1234);
      wr(8'h7F, 16'h1234);
      rd(ADDR_IDLE, 16'h0155);
      rd(ADDR_ALIGN, 16'h02AA);
      rd(ADDR_FRM, 16'h007F);
      rd(ADDR_ERR, 16'h0001);
      rd(8'h7F, 16'h0000);
      idle_w <= 10'h155;
      align_w <= 10'h2AA;
      repeat (8) @(posedge link_clk);
      #1;
      chk(16'(lane_data), 16'h0155);
      chk(16'(lane_sync), 16'h02AA);
      close_out();
   end
endmodule

// [verification/pdb_rx_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Lane receiver model: word lock, then capture of non-idle words
// ----------------------------------------------------------------
module pdb_rx_model (
   input  wire logic       link_clk,
   input  wire logic       nrst,
   input  wire logic [9:0] lane_data,
   input  wire logic [9:0] lane_sync,
   input  wire logic [9:0] idle_word,
   input  wire logic [9:0] align_code,
   output logic            locked
);
   logic [9:0] dq [64];
   logic [9:0] sq [64];
   int         td [64];
   int         ts [64];
   int         nd;
   int         ns;
   int         cyc;
   int         run;

   // lock on training
   // Four clean idle pairs in a row, so one stray word never locks
   always @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         nd <= 0;
         ns <= 0;
         cyc <= 0;
         run <= 0;
         locked <= 1'b0;
      end else begin
         cyc <= cyc + 1;
         if (lane_data === idle_word && lane_sync === align_code) begin
            run <= run + 1;
            if (run >= 3) locked <= 1'b1;
         end else begin
            run <= 0;
         end
         // Lanes are logged apart: narrow mode skews sync against data
         if (locked && lane_data !== idle_word) begin
            dq[nd] <= lane_data;
            td[nd] <= cyc;
            nd <= nd + 1;
         end
         if (locked && lane_sync !== align_code) begin
            sq[ns] <= lane_sync;
            ts[ns] <= cyc;
            ns <= ns + 1;
         end
      end
   end
endmodule
